// *** include/msc_pkg.sv ***
// Constants and carrier types for the module standby and clock output control.
// Assumes a single 40 MHz system clock domain and an AXI4-Lite register master.
package msc_pkg;

    // Register byte addresses
    localparam logic [7:0] MSC_OFS_CTRL_HIGH = 8'h00;
    localparam logic [7:0] MSC_OFS_CTRL_LOW = 8'h04;
    localparam logic [7:0] MSC_OFS_STATUS = 8'h08;

    // Field positions and widths
    localparam int MSC_HIGH_STOP_W = 3;
    localparam int MSC_LOW_STOP_W = 8;
    localparam int MSC_NUM_MOD = 11;
    localparam int MSC_CLKOUT_STOP_BIT = 7;

    // Reset values
    localparam logic [2:0] MSC_HIGH_STOP_RST = 3'h0;
    localparam logic [7:0] MSC_LOW_STOP_RST = 8'h00;
    localparam logic MSC_CLKOUT_STOP_RST = 1'b0;

    // Value a halted module returns on reads
    localparam logic [7:0] MSC_HALT_READ = 8'hFF;

    // AXI responses
    localparam logic [1:0] MSC_RESP_OKAY = 2'h0;
    localparam logic [1:0] MSC_RESP_SLVERR = 2'h2;

    // Operating states of the chip
    typedef enum logic [3:0] {
        MSC_OP_NORMAL = 4'h1,
        MSC_OP_SLEEP = 4'h2,
        MSC_OP_SW_STBY = 4'h4,
        MSC_OP_HW_STBY = 4'h8
    } msc_op_e;

    // Peripheral register port as seen by one stopped-or-running module
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } msc_preq_s;

endpackage

// *** core/msc_periph_gate.sv ***
// Per-module access gate: masks writes, forces reads and resets a halted module.
// Assumes module register reads are one byte on the same clock.
`timescale 1ns/1ps
module msc_periph_gate
    import msc_pkg::*;
#(
    parameter int NUM = MSC_NUM_MOD
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Stop vector
    input wire logic [NUM-1:0] stopVec,
    // Requests from the bus side and data from the modules
    input wire msc_preq_s [NUM-1:0] busReq,
    input wire logic [NUM*8-1:0] modRdata,
    // Gated towards modules, with read data back to the bus
    output msc_preq_s [NUM-1:0] modReq,
    output logic [NUM*8-1:0] busRdata,
    output logic [NUM-1:0] modRstN
);
    genvar g;
    generate
        for (g = 0; g < NUM; g++) begin : gGate
            assign modReq[g].wr = busReq[g].wr & ~stopVec[g];
            assign modReq[g].rd = busReq[g].rd & ~stopVec[g];
            assign modReq[g].wdata = busReq[g].wdata;
            assign busRdata[g*8 +: 8] = stopVec[g] ? MSC_HALT_READ : modRdata[g*8 +: 8];
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    modRstN[g] <= 1'b0;
                end else begin
                    modRstN[g] <= ~stopVec[g];
                end
            end
        end
    endgenerate
endmodule

// *** core/msc_clkout.sv ***
// Clock output pin drive per operating state and the clock-output stop bit.
// Assumes the pin pad resolves high impedance from the enable.
`timescale 1ns/1ps
module msc_clkout
    import msc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic stopOut,
    input wire msc_op_e opState,
    // Pin
    output logic pinLevel,
    output logic pinOe
);
    // Level select flop; the pad passes the running clock while pinLevel is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinLevel <= 1'b1;
            pinOe <= 1'b1;
        end else begin
            if (stopOut || opState == MSC_OP_HW_STBY) begin
                pinOe <= 1'b0;
                pinLevel <= 1'b0;
            end else if (opState == MSC_OP_SW_STBY) begin
                pinOe <= 1'b1;
                pinLevel <= 1'b1;
            end else begin
                pinOe <= 1'b1;
                pinLevel <= 1'b0;
            end
        end
    end
endmodule

// *** core/msc_standby_ctrl.sv ***
// Module standby and clock output control, top level with AXI4-Lite slave.
// Assumes CPU and DMA share one AXI4-Lite port; the DMA marks its accesses with a master id.
// Limitation: a DMA write is told apart by awFromDma alone, not by an AXI id.
//
// What this block does
// - Independent stop for each supporting module
// - High and low stop registers
// - Stop takes effect after the write
// - Halted module reads return FF
// - Writes to halted module discarded
// - Halted module registers reset to initial
// - Halted module pins revert to ports
// - CPU reads/writes, DMA reads only
// - Clock stop bit set: pin Hi-Z
// - Bit clear: clock out normal/sleep
// - Software standby high, hardware standby Hi-Z
// - Hardware standby resets modules, ports Hi-Z
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module msc_standby_ctrl
    import msc_pkg::*;
#(
    parameter int NUM = MSC_NUM_MOD,
    // Position of each module in the 11-bit stop vector {high[2:0], low[7:0]}
    parameter logic [3:0] MAP_SERIAL0 = 4'h0,
    parameter logic [3:0] MAP_SERIAL1 = 4'h1,
    parameter logic [3:0] MAP_SERIAL2 = 4'h2,
    parameter logic [3:0] MAP_DMA = 4'h3,
    parameter logic [3:0] MAP_TIMER16 = 4'h4,
    parameter logic [3:0] MAP_TIMER8 = 4'h5,
    parameter logic [3:0] MAP_DRAM = 4'h6,
    parameter logic [3:0] MAP_ADC = 4'h7
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Master of the current write, high when the DMA controller issues it
    input wire logic awFromDma,
    // Chip operating state pins (from outside, synchronised here)
    input wire logic hwStandbyPin,
    input wire logic swStandby,
    input wire logic sleepMode,
    // Peripheral register ports
    input wire msc_preq_s [NUM-1:0] busReq,
    input wire logic [NUM*8-1:0] modRdata,
    output msc_preq_s [NUM-1:0] modReq,
    output logic [NUM*8-1:0] busRdata,
    // Per-module reset and pin ownership
    output logic [NUM-1:0] modRstN,
    output logic [NUM-1:0] pinFuncEn,
    output logic portHiZ,
    // Named module stop lines
    output logic [7:0] namedStop,
    // Clock output pin
    output logic clkPinLevel,
    output logic clkPinOe
);
    ////////////////////////////////////////////////////////////////////////
    // Synchronisers and operating state
    logic [2:0] syncA_r;
    logic [2:0] syncB_r;
    msc_op_e opState;
    logic [NUM-1:0] gateRstN;
    logic [NUM-1:0] stopVec;

    // Two stages: the standby levels come from outside this clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_r <= 3'h0;
            syncB_r <= 3'h0;
        end else begin
            syncA_r <= {hwStandbyPin, swStandby, sleepMode};
            syncB_r <= syncA_r;
        end
    end

    // Hardware standby outranks every other state
    always_comb begin
        if (syncB_r[2]) begin
            opState = MSC_OP_HW_STBY;
        end else if (syncB_r[1]) begin
            opState = MSC_OP_SW_STBY;
        end else if (syncB_r[0]) begin
            opState = MSC_OP_SLEEP;
        end else begin
            opState = MSC_OP_NORMAL;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    logic [2:0] highStop_r;
    logic [7:0] lowStop_r;
    logic clkStop_r;
    logic awHeld_r;
    logic wHeld_r;
    logic [7:0] awAddr_r;
    logic awDma_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic doWrite;
    logic wrMapped;
    logic [1:0] wrSel;

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    // One-hot select of the control register at an address, zero if unmapped
    function automatic logic [1:0] ctrlSel(input logic [7:0] addr);
        ctrlSel = 2'b00;
        if (addr == MSC_OFS_CTRL_HIGH) begin
            ctrlSel = 2'b01;
        end else if (addr == MSC_OFS_CTRL_LOW) begin
            ctrlSel = 2'b10;
        end
    endfunction

    // The answer must drain first, so only one write is ever under way
    assign doWrite = awHeld_r && wHeld_r && !bvalid;
    assign wrSel = ctrlSel(awAddr_r);
    assign wrMapped = |wrSel;

    // Address and data taken in either order
    // Each item is latched on its own handshake and waits for the other
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            awDma_r <= 1'b0;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= awaddr;
                awDma_r <= awFromDma;
            end else if (doWrite) begin
                awHeld_r <= 1'b0;
            end
            if (wvalid && wready) begin
                wHeld_r <= 1'b1;
                wData_r <= wdata;
                wStrb_r <= wstrb;
            end else if (doWrite) begin
                wHeld_r <= 1'b0;
            end
        end
    end

    // Ready drops while an item is held, so nothing overwrites it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awready <= 1'b1;
            wready <= 1'b1;
        end else begin
            awready <= !(awvalid && awready) && !awHeld_r;
            wready <= !(wvalid && wready) && !wHeld_r;
            if (doWrite) begin
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Stop bits sit in two registers; the rest of each byte reads zero, except bit 7 of the high register, which holds the clock stop bit
    // Reset clears stops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            highStop_r <= MSC_HIGH_STOP_RST;
            lowStop_r <= MSC_LOW_STOP_RST;
            clkStop_r <= MSC_CLKOUT_STOP_RST;
        // DMA writes blocked
        // Only byte 0 carries control bits, so its strobe decides
        end else if (doWrite && !awDma_r && wStrb_r[0]) begin
            if (wrSel[0]) begin
                highStop_r <= wData_r[MSC_HIGH_STOP_W-1:0];
                clkStop_r <= wData_r[MSC_CLKOUT_STOP_BIT];
            end else if (wrSel[1]) begin
                lowStop_r <= wData_r[MSC_LOW_STOP_W-1:0];
            end
        end
    end

    // DMA and unmapped writes are answered with an error and change nothing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp <= MSC_RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= (wrMapped && !awDma_r) ? MSC_RESP_OKAY : MSC_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel
    // Reads open to all
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= MSC_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= MSC_RESP_OKAY;
            case (araddr)
                MSC_OFS_CTRL_HIGH: rdata <= {24'h0, clkStop_r, 4'h0, highStop_r};
                MSC_OFS_CTRL_LOW: rdata <= {24'h0, lowStop_r};
                // Status lags the pins by the two synchroniser stages
                MSC_OFS_STATUS: rdata <= {28'h0, opState};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= MSC_RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stop vector, module gating and pins
    // Halt on next cycle
    // Hardware standby stops all
    // Order is {high, low}; low bit 0 is index 0
    assign stopVec = {highStop_r, lowStop_r} | {NUM{opState == MSC_OP_HW_STBY}};

    // The gate resets a halted module one edge after its stop rises
    msc_periph_gate #(
        .NUM(NUM)
    ) uGate (
        .clk(clk),
        .rst_n(rst_n),
        .stopVec(stopVec),
        .busReq(busReq),
        .modRdata(modRdata),
        .modReq(modReq),
        .busRdata(busRdata),
        .modRstN(gateRstN)
    );
    assign modRstN = gateRstN;

    // Picks the eight named stop lines out of the stop vector by the map
    function automatic logic [7:0] namedOf(input logic [NUM-1:0] s);
        namedOf = {s[MAP_ADC], s[MAP_DRAM], s[MAP_TIMER8], s[MAP_TIMER16],
            s[MAP_DMA], s[MAP_SERIAL2], s[MAP_SERIAL1], s[MAP_SERIAL0]};
    endfunction

    // Pins revert to port
    // Registered, so pin ownership moves one edge after the stop bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            namedStop <= 8'h00;
            pinFuncEn <= '0;
            portHiZ <= 1'b0;
        end else begin
            namedStop <= namedOf(stopVec);
            pinFuncEn <= ~stopVec;
            portHiZ <= (opState == MSC_OP_HW_STBY);
        end
    end

    // The pad mixes in the running clock; only level and enable come from here
    msc_clkout uClk (
        .clk(clk),
        .rst_n(rst_n),
        .stopOut(clkStop_r),
        .opState(opState),
        .pinLevel(clkPinLevel),
        .pinOe(clkPinOe)
    );
endmodule

// *** verif/msc_periph_model.sv ***
// Far-side model: one byte register per supporting module.
// Assumes gated requests and per-module resets from the standby block.
`timescale 1ns/1ps
module msc_periph_model
    import msc_pkg::*;
#(
    parameter int NUM = MSC_NUM_MOD,
    parameter logic [7:0] INIT = 8'h3C
) (
    // Clock
    input wire logic clk,
    // From the block
    input wire msc_preq_s [NUM-1:0] modReq,
    input wire logic [NUM-1:0] modRstN,
    // To the block
    output logic [NUM*8-1:0] modRdata
);
    logic [7:0] regs_r [NUM];
    for (genvar i = 0; i < NUM; i++) begin : g_m
        always_ff @(posedge clk or negedge modRstN[i]) begin
            if (!modRstN[i]) begin
                regs_r[i] <= INIT;
            end else if (modReq[i].wr) begin
                regs_r[i] <= modReq[i].wdata;
            end
        end
        // Drives no receive pins
        // Idle lines show inverted data so a stale byte never passes
        assign modRdata[8*i+:8] = modReq[i].rd ? regs_r[i] : ~regs_r[i];
    end
endmodule

// *** verif/msc_standby_ctrl_sva.sv ***
// Port-level checks of the standby control block.
// Assumes the default module map and one clock domain.
`timescale 1ns/1ps
module msc_standby_ctrl_sva
    import msc_pkg::*;
#(
    parameter int NUM = MSC_NUM_MOD
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic awFromDma,
    input wire logic hwStandbyPin,
    // Modules and pins
    input wire msc_preq_s [NUM-1:0] modReq,
    input wire logic [NUM*8-1:0] modRdata,
    input wire logic [NUM*8-1:0] busRdata,
    input wire logic [NUM-1:0] modRstN,
    input wire logic [NUM-1:0] pinFuncEn,
    input wire logic portHiZ,
    input wire logic [7:0] namedStop,
    input wire logic clkPinOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    wr_resp_a: assert property (wr_taken |-> ##2 bvalid)
        else $error("write answer late");
    dma_block_a: assert property ((wr_taken ##0 awFromDma) |-> ##2 bresp == MSC_RESP_SLVERR)
        else $error("dma write not refused");
    b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    rd_resp_a: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped");
    pin_owner_a: assert property (pinFuncEn == modRstN)
        else $error("pin ownership wrong");
    named_stop_a: assert property ($past(rst_n) |-> namedStop == ~modRstN[7:0])
        else $error("named stop lines wrong");
    hw_hiz_a: assert property (hwStandbyPin [*6] |-> !clkPinOe && portHiZ && modRstN == '0)
        else $error("hardware standby not applied");
    for (genvar i = 0; i < NUM; i++) begin : g_a
        halt_read_a: assert property (!modRstN[i] && $past(rst_n) |-> $past(busRdata[8*i+:8]) == MSC_HALT_READ)
            else $error("halted read not FF");
        halt_write_a: assert property (!modRstN[i] && $past(rst_n) |-> !$past(modReq[i].wr))
            else $error("halted write passed");
        pass_read_a: assert property (modRstN[i] |-> $past(busRdata[8*i+:8]) == $past(modRdata[8*i+:8]))
            else $error("running read altered");
    end
endmodule
bind msc_standby_ctrl msc_standby_ctrl_sva #(.NUM(NUM)) msc_standby_ctrl_sva_i (.clk, .rst_n,
    .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata,
    .rvalid, .rready, .awFromDma, .hwStandbyPin, .modReq, .modRdata, .busRdata, .modRstN,
    .pinFuncEn, .portHiZ, .namedStop, .clkPinOe);

// *** verif/test_module_standby_and_clock_output_ctrl.sv ***
// Self-checking bench: AXI4-Lite master, module accesses, clock pin modes.
// Assumes the peripheral model on the far side and the default module map.
`timescale 1ns/1ps
module test_module_standby_and_clock_output_ctrl;
    import msc_pkg::*;
    localparam int N = MSC_NUM_MOD;
    logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, v;
    logic [31:0] wdata = 0, rd;
    logic [3:0] wstrb = 4'hF;
    logic awFromDma = 0, hwStandbyPin = 0, swStandby = 0, sleepMode = 0, ck;
    msc_preq_s [N-1:0] busReq = '0;
    wire logic awready, wready, bvalid, arready, rvalid, portHiZ, clkPinLevel, clkPinOe;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [N*8-1:0] modRdata, busRdata;
    wire msc_preq_s [N-1:0] modReq;
    wire logic [N-1:0] modRstN, pinFuncEn;
    wire logic [7:0] namedStop;
    int num_errors = 0, n_checks = 0, cyc = 0;
    logic [7:0] expReg [N];
    logic [1:0] resp;
    logic [10:0] stp = '0, nxt;
    always #12.5 clk = ~clk;
    msc_standby_ctrl msc_standby_ctrl_i (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .awFromDma, .hwStandbyPin, .swStandby, .sleepMode, .busReq,
        .modRdata, .modReq, .busRdata, .modRstN, .pinFuncEn, .portHiZ, .namedStop,
        .clkPinLevel, .clkPinOe);
    msc_periph_model msc_periph_model_i (.clk, .modReq, .modRstN, .modRdata);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic dma);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awFromDma <= dma;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic poke(input int i, input logic [7:0] d);
        @(posedge clk);
        busReq[i].wr <= 1'b1;
        busReq[i].wdata <= d;
        @(posedge clk);
        busReq[i].wr <= 1'b0;
    endtask
    task automatic peek(input int i, input logic [7:0] e);
        @(posedge clk);
        busReq[i].rd <= 1'b1;
        @(negedge clk);
        chk("busRdata", busRdata[8*i+:8], e);
        @(posedge clk);
        busReq[i].rd <= 1'b0;
    endtask
    task automatic wrap_up();
        $display("Checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Long enough for all scenarios with wide margin
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(32'h64d3));
        for (int i = 0; i < N; i++) expReg[i] = 8'h3C;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        axr(MSC_OFS_CTRL_HIGH);
        chk("high", rd, 32'h0);
        axr(MSC_OFS_CTRL_LOW);
        chk("low", rd, 32'h0);
        chk("clkOe", clkPinOe, 1'b1);
        for (int k = 0; k < 8; k++) begin
            for (int i = 0; i < N; i++) begin
                v = 8'($urandom);
                poke(i, v);
                if (!stp[i]) expReg[i] = v;
            end
            nxt = (k == 7) ? 11'h000 : (k == 0) ? 11'h7FF : 11'($urandom);
            ck = (k == 7) ? 1'b0 : 1'($urandom);
            axw(MSC_OFS_CTRL_LOW, {24'h0, nxt[7:0]}, 1'b0);
            axw(MSC_OFS_CTRL_HIGH, {24'h0, ck, 4'h0, nxt[10:8]}, 1'b0);
            for (int i = 0; i < N; i++) if (nxt[i]) expReg[i] = 8'h3C;
            axr(MSC_OFS_CTRL_LOW);
            chk("low", rd, {24'h0, nxt[7:0]});
            axr(MSC_OFS_CTRL_HIGH);
            chk("high", rd, {24'h0, ck, 4'h0, nxt[10:8]});
            chk("pinEn", pinFuncEn, 11'(~nxt));
            chk("named", namedStop, nxt[7:0]);
            chk("clkOe", clkPinOe, !ck);
            for (int i = 0; i < N; i++) begin
                peek(i, nxt[i] ? MSC_HALT_READ : expReg[i]);
                v = 8'($urandom);
                poke(i, v);
                if (!nxt[i]) expReg[i] = v;
                peek(i, nxt[i] ? MSC_HALT_READ : expReg[i]);
            end
            stp = nxt;
        end
        axw(MSC_OFS_CTRL_LOW, 32'hFF, 1'b1);
        chk("dmaResp", resp, MSC_RESP_SLVERR);
        axr(MSC_OFS_CTRL_LOW);
        chk("dmaKeep", rd, 32'h0);
        axw(8'h0C, 32'h1, 1'b0);
        chk("badW", resp, MSC_RESP_SLVERR);
        axr(8'h0C);
        chk("badR", resp, MSC_RESP_SLVERR);
        wstrb <= 4'h0;
        axw(MSC_OFS_CTRL_LOW, 32'hFF, 1'b0);
        chk("strbResp", resp, MSC_RESP_OKAY);
        wstrb <= 4'hF;
        axr(MSC_OFS_CTRL_LOW);
        chk("strbKeep", rd, 32'h0);
        for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            {hwStandbyPin, swStandby, sleepMode} <= 3'b001 << m;
            repeat (8) @(posedge clk);
            axr(MSC_OFS_STATUS);
            chk("status", rd, 32'h2 << m);
            chk("clkOe", clkPinOe, m != 2);
            chk("clkLvl", clkPinLevel | (m == 2), m != 0);
        end
        chk("portHiZ", portHiZ, 1'b1);
        chk("modRst", modRstN, '0);
        @(posedge clk);
        {hwStandbyPin, swStandby, sleepMode} <= 3'b010;
        repeat (8) @(posedge clk);
        axw(MSC_OFS_CTRL_HIGH, 32'h80, 1'b0);
        repeat (4) @(posedge clk);
        chk("clkOeStop", clkPinOe, 1'b0);
        wrap_up();
    end
endmodule
